// ===== logic/clock_enable_gating.sv
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
// Operation
// - halt signal asserts, stopping the whole generator, while stop mode is on
// - during halt, internal, external and base clocks are held low
// - internal enable is internal-on bit and not halt
// - internal enable off keeps internal clock and base clock low
// - external enable is external-on bit and not halt
// - external enable off keeps external clock low
// - bus clock is a quarter of oscillator clock, half of generator clock
// - oscillator output clock and separate generator output clock are provided
// - internal clock is software-programmed integer multiple of base frequency
// - software selects internal or external generator as bus clock source
// - filter-stable flag set when base frequency error is under five percent
module clock_enable_gating (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic STOP_MODE,
	input wire logic EXT_CLK_IN,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	output logic GENERATOR_HALT,
	output logic INTERNAL_GEN_ENABLE,
	output logic EXTERNAL_GEN_ENABLE,
	output logic INTERNAL_OSC_CLOCK,
	output logic EXTERNAL_OSC_CLOCK,
	output logic LOW_FREQ_BASE_CLOCK,
	output logic OSCILLATOR_OUTPUT_CLOCK,
	output logic GENERATOR_OUTPUT_CLOCK,
	output logic BUS_CLOCK,
	output logic FILTER_STABLE_FLAG
);

	////////////////////////////////////////////////////////////////////////
	// address decode

	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] o);
		addr_hit = (a == o);
	endfunction

	logic [7:0] ctrl_reg;
	logic [6:0] mult_reg;
	logic [7:0] trim_reg;
	logic [7:0] rdata_next;
	logic [7:0] status;
	logic internal_on_bit;
	logic external_on_bit;
	logic sel_ext_bit;
	logic sel_active_reg;
	logic int_enable_next;

	assign internal_on_bit = ctrl_reg[clock_enable_gating_pkg::CTRL_INT_ON_BIT];
	assign external_on_bit = ctrl_reg[clock_enable_gating_pkg::CTRL_EXT_ON_BIT];
	assign sel_ext_bit = ctrl_reg[clock_enable_gating_pkg::CTRL_SEL_EXT_BIT];
	assign int_enable_next = internal_on_bit && !STOP_MODE;

	////////////////////////////////////////////////////////////////////////
	// software registers

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ctrl_reg <= clock_enable_gating_pkg::CTRL_RESET;
		end else if (WR && addr_hit(ADDR, clock_enable_gating_pkg::CTRL_OFS)) begin
			ctrl_reg <= {5'h0, WDATA[2:0]};
		end
	end

	// multiplier factor for the internal generator
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			mult_reg <= clock_enable_gating_pkg::MULT_RESET;
		end else if (WR && addr_hit(ADDR, clock_enable_gating_pkg::MULT_OFS)) begin
			mult_reg <= WDATA[6:0];
		end
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			trim_reg <= clock_enable_gating_pkg::TRIM_RESET;
		end else if (WR && addr_hit(ADDR, clock_enable_gating_pkg::TRIM_OFS)) begin
			trim_reg <= WDATA;
		end
	end

	always_comb begin
		status = 8'h00;
		status[clock_enable_gating_pkg::STAT_INT_EN_BIT] = INTERNAL_GEN_ENABLE;
		status[clock_enable_gating_pkg::STAT_EXT_EN_BIT] = EXTERNAL_GEN_ENABLE;
		status[clock_enable_gating_pkg::STAT_HALT_BIT] = GENERATOR_HALT;
		status[clock_enable_gating_pkg::STAT_STABLE_BIT] = FILTER_STABLE_FLAG;
		status[clock_enable_gating_pkg::STAT_SEL_BIT] = sel_active_reg;
	end

	always_comb begin
		rdata_next = clock_enable_gating_pkg::ZERO_BYTE;
		if (RD) begin
			unique case (ADDR)
				clock_enable_gating_pkg::CTRL_OFS: rdata_next = ctrl_reg;
				clock_enable_gating_pkg::MULT_OFS: rdata_next = {1'b0, mult_reg};
				clock_enable_gating_pkg::TRIM_OFS: rdata_next = trim_reg;
				clock_enable_gating_pkg::STAT_OFS: rdata_next = status;
				default: rdata_next = clock_enable_gating_pkg::ZERO_BYTE;
			endcase
		end
	end

	// read data stands only in the cycle after the read strobe
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			RDATA <= clock_enable_gating_pkg::ZERO_BYTE;
		end else begin
			RDATA <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// enables

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			GENERATOR_HALT <= 1'b0;
			INTERNAL_GEN_ENABLE <= 1'b0;
			EXTERNAL_GEN_ENABLE <= 1'b0;
		end else begin
			GENERATOR_HALT <= STOP_MODE;
			INTERNAL_GEN_ENABLE <= int_enable_next;
			EXTERNAL_GEN_ENABLE <= external_on_bit && !STOP_MODE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// internal oscillator: half period of trim+1 cycles

	logic [7:0] dco_cnt_reg;
	logic dco_reg;
	logic dco_tick;
	logic ick_rise;

	assign dco_tick = (dco_cnt_reg == trim_reg);
	assign ick_rise = dco_tick && !dco_reg && int_enable_next;

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			dco_cnt_reg <= 8'h00;
		end else if (!INTERNAL_GEN_ENABLE && !dco_reg) begin
			dco_cnt_reg <= 8'h00;
		end else if (dco_tick) begin
			dco_cnt_reg <= 8'h00;
		end else begin
			dco_cnt_reg <= dco_cnt_reg + 8'h01;
		end
	end

	// no new high phase once the enable is about to drop
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			dco_reg <= 1'b0;
		end else if (dco_tick && (dco_reg || int_enable_next)) begin
			dco_reg <= !dco_reg;
		end
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			INTERNAL_OSC_CLOCK <= 1'b0;
		end else begin
			INTERNAL_OSC_CLOCK <= dco_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// base clock: internal clock divided by the multiplier

	logic [6:0] div_cnt_reg;
	logic base_raw_reg;
	logic pass_through;

	assign pass_through = (mult_reg <= 7'h01);

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			div_cnt_reg <= 7'h00;
		end else if (pass_through || !INTERNAL_GEN_ENABLE) begin
			div_cnt_reg <= 7'h00;
		end else if (ick_rise) begin
			if (div_cnt_reg >= mult_reg - 7'h01) begin
				div_cnt_reg <= 7'h00;
			end else begin
				div_cnt_reg <= div_cnt_reg + 7'h01;
			end
		end
	end

	// base high for the first half of each multiplier period
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			base_raw_reg <= 1'b0;
		end else if (pass_through) begin
			base_raw_reg <= dco_reg;
		end else if (ick_rise) begin
			base_raw_reg <= (div_cnt_reg < (mult_reg >> 1)) ||
				(div_cnt_reg == 7'h00);
		end else if (!dco_reg && !INTERNAL_GEN_ENABLE) begin
			base_raw_reg <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			LOW_FREQ_BASE_CLOCK <= 1'b0;
		end else begin
			LOW_FREQ_BASE_CLOCK <= base_raw_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// external clock gate, enable only changes while the input is low

	logic ext_gate_reg;

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ext_gate_reg <= 1'b0;
		end else if (!EXT_CLK_IN) begin
			ext_gate_reg <= EXTERNAL_GEN_ENABLE;
		end
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			EXTERNAL_OSC_CLOCK <= 1'b0;
		end else begin
			EXTERNAL_OSC_CLOCK <= EXT_CLK_IN && ext_gate_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// source selection, switched only while both sources rest low

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			sel_active_reg <= 1'b0;
		end else if (!INTERNAL_OSC_CLOCK && !EXTERNAL_OSC_CLOCK) begin
			sel_active_reg <= sel_ext_bit;
		end
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			OSCILLATOR_OUTPUT_CLOCK <= 1'b0;
		end else if (sel_active_reg) begin
			OSCILLATOR_OUTPUT_CLOCK <= EXTERNAL_OSC_CLOCK;
		end else begin
			OSCILLATOR_OUTPUT_CLOCK <= INTERNAL_OSC_CLOCK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// generator output and bus clock dividers

	logic osc_prev_reg;
	logic gen_prev_reg;
	logic osc_rise;
	logic gen_rise;

	assign osc_rise = OSCILLATOR_OUTPUT_CLOCK && !osc_prev_reg;
	assign gen_rise = GENERATOR_OUTPUT_CLOCK && !gen_prev_reg;

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			osc_prev_reg <= 1'b0;
			gen_prev_reg <= 1'b0;
		end else begin
			osc_prev_reg <= OSCILLATOR_OUTPUT_CLOCK;
			gen_prev_reg <= GENERATOR_OUTPUT_CLOCK;
		end
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			GENERATOR_OUTPUT_CLOCK <= 1'b0;
		end else if (osc_rise) begin
			GENERATOR_OUTPUT_CLOCK <= !GENERATOR_OUTPUT_CLOCK;
		end
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			BUS_CLOCK <= 1'b0;
		end else if (gen_rise) begin
			BUS_CLOCK <= !BUS_CLOCK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// base period measurement and filter-stable flag

	logic base_prev_reg;
	logic base_rise;
	logic [15:0] period_cnt_reg;
	logic in_band;
	logic base_seen_reg;

	assign base_rise = LOW_FREQ_BASE_CLOCK && !base_prev_reg;
	assign in_band = (period_cnt_reg >= clock_enable_gating_pkg::LOW_PERIOD) &&
		(period_cnt_reg <= clock_enable_gating_pkg::HIGH_PERIOD);

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			base_prev_reg <= 1'b0;
		end else begin
			base_prev_reg <= LOW_FREQ_BASE_CLOCK;
		end
	end

	// cycles since the last base rising edge, saturating
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			period_cnt_reg <= 16'h0000;
		end else if (base_rise || !INTERNAL_GEN_ENABLE) begin
			period_cnt_reg <= 16'h0001;
		end else if (period_cnt_reg != clock_enable_gating_pkg::PERIOD_MAX) begin
			period_cnt_reg <= period_cnt_reg + 16'h0001;
		end
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			FILTER_STABLE_FLAG <= 1'b0;
		end else if (!INTERNAL_GEN_ENABLE) begin
			FILTER_STABLE_FLAG <= 1'b0;
		end else if (base_rise && base_seen_reg) begin
			FILTER_STABLE_FLAG <= in_band;
		end else if (period_cnt_reg > clock_enable_gating_pkg::HIGH_PERIOD) begin
			FILTER_STABLE_FLAG <= 1'b0;
		end
	end

	// first edge after enabling only starts the measurement
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			base_seen_reg <= 1'b0;
		end else if (!INTERNAL_GEN_ENABLE) begin
			base_seen_reg <= 1'b0;
		end else if (base_rise) begin
			base_seen_reg <= 1'b1;
		end
	end

endmodule

// ===== logic/clock_enable_gating_pkg.sv
package clock_enable_gating_pkg;

	// register port geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] MULT_OFS = 8'h04;
	localparam logic [7:0] TRIM_OFS = 8'h08;
	localparam logic [7:0] STAT_OFS = 8'h0C;

	// control register fields
	localparam int CTRL_INT_ON_BIT = 0;
	localparam int CTRL_EXT_ON_BIT = 1;
	localparam int CTRL_SEL_EXT_BIT = 2;

	// status register fields
	localparam int STAT_INT_EN_BIT = 0;
	localparam int STAT_EXT_EN_BIT = 1;
	localparam int STAT_HALT_BIT = 2;
	localparam int STAT_STABLE_BIT = 3;
	localparam int STAT_SEL_BIT = 4;

	// reset values
	localparam logic [7:0] CTRL_RESET = 8'h01;
	localparam logic [6:0] MULT_RESET = 7'h01;
	localparam logic [7:0] TRIM_RESET = 8'h10;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// multiplier field and period counter widths
	localparam int MULT_W = 7;
	localparam int PERIOD_W = 16;

	// timing: system clock and nominal base frequency
	localparam int CLK_FREQ_HZ = 100_000_000;
	localparam int NOM_FREQ_DHZ = 3_072_000;
	localparam int TOL_PERCENT = 5;
	localparam int NOM_PERIOD_CYC = (CLK_FREQ_HZ / NOM_FREQ_DHZ) * 10
		+ ((CLK_FREQ_HZ % NOM_FREQ_DHZ) * 10) / NOM_FREQ_DHZ;
	localparam int LOW_PERIOD_CYC =
		(NOM_PERIOD_CYC * (100 - TOL_PERCENT) + 99) / 100;
	localparam int HIGH_PERIOD_CYC =
		(NOM_PERIOD_CYC * (100 + TOL_PERCENT)) / 100;
	localparam logic [15:0] LOW_PERIOD = 16'(LOW_PERIOD_CYC);
	localparam logic [15:0] HIGH_PERIOD = 16'(HIGH_PERIOD_CYC);
	localparam logic [15:0] PERIOD_MAX = 16'hFFFF;

endpackage

// ===== testbench/clock_enable_gating_assertions.sv
`timescale 1ns/10ps
module clock_enable_gating_checker (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic STOP_MODE,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	input wire logic GENERATOR_HALT,
	input wire logic INTERNAL_GEN_ENABLE,
	input wire logic EXTERNAL_GEN_ENABLE,
	input wire logic INTERNAL_OSC_CLOCK,
	input wire logic EXTERNAL_OSC_CLOCK,
	input wire logic LOW_FREQ_BASE_CLOCK,
	input wire logic OSCILLATOR_OUTPUT_CLOCK,
	input wire logic GENERATOR_OUTPUT_CLOCK,
	input wire logic BUS_CLOCK,
	input wire logic FILTER_STABLE_FLAG
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);
	// cycles with the internal enable off, saturating at 300
	logic [8:0] off_cnt_reg;
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			off_cnt_reg <= 9'h000;
		end else if (INTERNAL_GEN_ENABLE) begin
			off_cnt_reg <= 9'h000;
		end else if (off_cnt_reg != 9'h12C) begin
			off_cnt_reg <= off_cnt_reg + 9'h001;
		end
	end
	AST_HALT: assert property (STOP_MODE |=> GENERATOR_HALT)
		else $error("halt not raised in stop mode");
	AST_STOP_ENABLES: assert property (
		STOP_MODE |=> !INTERNAL_GEN_ENABLE && !EXTERNAL_GEN_ENABLE)
		else $error("enable active in stop mode");
	AST_INT_ON: assert property (
		WR && ADDR == clock_enable_gating_pkg::CTRL_OFS && !STOP_MODE &&
		WDATA[clock_enable_gating_pkg::CTRL_INT_ON_BIT] ##1 !STOP_MODE
		|=> INTERNAL_GEN_ENABLE)
		else $error("internal enable not set");
	AST_INT_LOW: assert property (
		!INTERNAL_GEN_ENABLE && !INTERNAL_OSC_CLOCK |=> !INTERNAL_OSC_CLOCK)
		else $error("internal clock rose while disabled");
	AST_BASE_OFF: assert property (
		off_cnt_reg == 9'h12C |-> !INTERNAL_OSC_CLOCK && !LOW_FREQ_BASE_CLOCK)
		else $error("base clock not stopped");
	AST_EXT_LOW: assert property (
		!EXTERNAL_GEN_ENABLE && $past(!EXTERNAL_GEN_ENABLE)
		&& !EXTERNAL_OSC_CLOCK |=> !EXTERNAL_OSC_CLOCK)
		else $error("external clock rose while disabled");
	AST_GEN_DIV: assert property (
		$rose(OSCILLATOR_OUTPUT_CLOCK) |=> $changed(GENERATOR_OUTPUT_CLOCK))
		else $error("generator clock missed a toggle");
	AST_GEN_HOLD: assert property (
		!$rose(OSCILLATOR_OUTPUT_CLOCK) |=> $stable(GENERATOR_OUTPUT_CLOCK))
		else $error("generator clock toggled without cause");
	AST_BUS_DIV: assert property (
		$rose(GENERATOR_OUTPUT_CLOCK) |=> $changed(BUS_CLOCK))
		else $error("bus clock missed a toggle");
	AST_FILT_OFF: assert property (
		!INTERNAL_GEN_ENABLE [*2] |=> !FILTER_STABLE_FLAG)
		else $error("filter flag set while disabled");
	AST_RDATA_IDLE: assert property (!RD |=> RDATA == 8'h00)
		else $error("read data outside read cycle");
	COV_STOP: cover property ($rose(GENERATOR_HALT));
	COV_FILT: cover property ($rose(FILTER_STABLE_FLAG));
	COV_BUS: cover property ($rose(BUS_CLOCK));
endmodule
bind clock_enable_gating clock_enable_gating_checker i_chk (.SYS_CLK,
	.SYS_RST, .STOP_MODE, .ADDR, .WDATA, .WR, .RD, .RDATA, .GENERATOR_HALT,
	.INTERNAL_GEN_ENABLE, .EXTERNAL_GEN_ENABLE, .INTERNAL_OSC_CLOCK,
	.EXTERNAL_OSC_CLOCK, .LOW_FREQ_BASE_CLOCK, .OSCILLATOR_OUTPUT_CLOCK,
	.GENERATOR_OUTPUT_CLOCK, .BUS_CLOCK, .FILTER_STABLE_FLAG);

// ===== testbench/clock_consumer_model.sv
`timescale 1ns/10ps
// far side: external oscillator source and clock consumers
module clock_consumer_model #(
	parameter int EXT_HALF = 3
) (
	input wire logic clk,
	input wire logic run,
	input wire logic [4:0] clks,
	output logic ext_clk,
	output int cnt [5]
);
	int ph;
	logic [4:0] prev;
	initial begin
		ext_clk = 1'b0;
		ph = 0;
		prev = 5'h0;
		for (int i = 0; i < 5; i++) cnt[i] = 0;
	end
	// oscillator stands low when not running
	always @(posedge clk) begin
		ph <= run ? (ph + 1) % EXT_HALF : 0;
		if (!run)
			ext_clk <= 1'b0;
		else if (ph == EXT_HALF - 1)
			ext_clk <= !ext_clk;
	end
	// consumers count rising edges of each delivered clock
	always @(posedge clk) begin
		prev <= clks;
		for (int i = 0; i < 5; i++)
			if (clks[i] && !prev[i]) cnt[i] <= cnt[i] + 1;
	end
endmodule

// ===== testbench/clock_enable_gating_bench.sv
`timescale 1ns/10ps
module clock_enable_gating_bench;
	typedef struct {logic [7:0] ctrl; logic stop; logic [2:0] st;} row_t;
	logic SYS_CLK = 0, SYS_RST = 1, STOP_MODE = 0, WR = 0, RD = 0, run = 0;
	logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA, d;
	logic halt, ie, ee, ic, ec, bc, oc, gc, bus, fl, ext;
	int cnt [5], c0 [5], mismatches = 0, check_count = 0, cycles = 0;
	row_t rows [6] = '{'{8'h01, 0, 3'h1}, '{8'h02, 0, 3'h2},
		'{8'h03, 1, 3'h4}, '{8'h03, 0, 3'h3}, '{8'h02, 1, 3'h4},
		'{8'h00, 0, 3'h0}};
	logic [7:0] trims [4] = '{8'hA9, 8'hAA, 8'h99, 8'h9A};
	logic fexp [4] = '{1, 0, 0, 1};
	always #5 SYS_CLK = !SYS_CLK;
	clock_enable_gating i_clock_enable_gating (.SYS_CLK(SYS_CLK),
		.SYS_RST(SYS_RST), .STOP_MODE(STOP_MODE), .EXT_CLK_IN(ext),
		.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.GENERATOR_HALT(halt), .INTERNAL_GEN_ENABLE(ie),
		.EXTERNAL_GEN_ENABLE(ee), .INTERNAL_OSC_CLOCK(ic),
		.EXTERNAL_OSC_CLOCK(ec), .LOW_FREQ_BASE_CLOCK(bc),
		.OSCILLATOR_OUTPUT_CLOCK(oc), .GENERATOR_OUTPUT_CLOCK(gc),
		.BUS_CLOCK(bus), .FILTER_STABLE_FLAG(fl));
	clock_consumer_model i_clock_consumer_model (.clk(SYS_CLK), .run(run),
		.clks({bc, ic, bus, gc, oc}), .ext_clk(ext), .cnt(cnt));
	////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge SYS_CLK);
		ADDR <= a;
		WDATA <= v;
		WR <= 1'b1;
		@(posedge SYS_CLK);
		WR <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge SYS_CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge SYS_CLK);
		RD <= 1'b0;
		#1 v = RDATA;
	endtask
	task wait_cyc(input int n);
		repeat (n) @(posedge SYS_CLK);
	endtask
	task do_reset;
		@(posedge SYS_CLK);
		SYS_RST <= 1'b1;
		wait_cyc(5);
		SYS_RST <= 1'b0;
	endtask
	// edge counts over a window, ratio checked to within one edge
	task measure(input int n);
		c0 = cnt;
		wait_cyc(n);
		#1 for (int i = 0; i < 5; i++) c0[i] = cnt[i] - c0[i];
	endtask
	function logic near(input int a, input int b);
		return a - b <= 1 && b - a <= 1;
	endfunction
	always @(posedge SYS_CLK) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			final_report;
		end
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		do_reset();
		rd(8'h00, d); check(d, 8'h01);
		rd(8'h04, d); check(d, 8'h01);
		rd(8'h08, d); check(d, 8'h10);
		rd(8'h10, d); check(d, 8'h00);
		run <= 1'b1;
		foreach (rows[i]) begin
			wr(8'h00, rows[i].ctrl);
			STOP_MODE <= rows[i].stop;
			wait_cyc(40);
			rd(8'h0C, d);
			check(d[2:0], rows[i].st);
			check({halt, ee, ie}, rows[i].st);
			if (!rows[i].st[0]) check({ic, bc}, 2'b00);
			if (!rows[i].st[1]) check(ec, 1'b0);
		end
		STOP_MODE <= 1'b0;
		wr(8'h00, 8'hFF);
		rd(8'h00, d); check(d, 8'h07);
		wr(8'h00, 8'h03);
		wr(8'h04, 8'h04);
		wr(8'h08, 8'h01);
		measure(2000);
		check(c0[4] > 0 && near(c0[4], c0[3] / 4), 1'b1);
		check(c0[0] > 0 && near(c0[1], c0[0] / 2), 1'b1);
		check(near(c0[2], c0[0] / 4), 1'b1);
		wr(8'h00, 8'h07);
		wait_cyc(40);
		rd(8'h0C, d); check(d[4], 1'b1);
		measure(1200);
		check(near(c0[0], 1200 / 6), 1'b1);
		check(near(c0[2], c0[0] / 4), 1'b1);
		wr(8'h00, 8'h01);
		wr(8'h04, 8'h01);
		foreach (trims[i]) begin
			wr(8'h08, trims[i]);
			wait_cyc(1400);
			check(fl, fexp[i]);
		end
		wr(8'h00, 8'h00);
		wait_cyc(400);
		check(fl, 1'b0);
		do_reset();
		rd(8'h00, d); check(d, 8'h01);
		final_report();
	end
endmodule
